// *** shared/mide_pkg.sv ***
// Shared constants, carriers and helpers for the instruction decode/execute core
package mide_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OSC_PER_INSTR = 4;

  typedef enum logic [1:0]
  {
    MIDE_Q1 = 2'b00,
    MIDE_Q2 = 2'b01,
    MIDE_Q3 = 2'b10,
    MIDE_Q4 = 2'b11
  } mide_q_e;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_ACC = 12'h008;
  localparam logic [11:0] REG_PC = 12'h00c;
  localparam logic [11:0] REG_PC_HIGH = 12'h010;

  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_PSA_BIT = 1;
  localparam int unsigned CTRL_WAKE_BIT = 2;

  localparam int unsigned ST_C_BIT = 0;
  localparam int unsigned ST_DC_BIT = 1;
  localparam int unsigned ST_Z_BIT = 2;
  localparam int unsigned ST_PWRDN_BIT = 3;
  localparam int unsigned ST_TMOUT_BIT = 4;
  localparam int unsigned ST_IRQ_EN_BIT = 5;
  localparam int unsigned ST_SLEEP_BIT = 6;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [4:0] RST_PC_HIGH = 5'h00;
  localparam logic RST_TIMEOUT = 1'b1;
  localparam logic RST_POWERDOWN = 1'b1;

  // ----------------------------------------
  // File register addresses
  // ----------------------------------------
  localparam logic [6:0] ADDR_TIMER_ZERO = 7'h01;
  localparam logic [6:0] ADDR_IO_PORT = 7'h06;

  // ----------------------------------------
  // Opcode fields
  // ----------------------------------------
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_BRANCH = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;

  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_IOR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOV = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'ha;
  localparam logic [3:0] OP_DECSZ = 4'hb;
  localparam logic [3:0] OP_RR = 4'hc;
  localparam logic [3:0] OP_RL = 4'hd;
  localparam logic [3:0] OP_SWAP = 4'he;
  localparam logic [3:0] OP_INCSZ = 4'hf;

  localparam logic [1:0] BOP_CLEAR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_SKIP_CLR = 2'h2;
  localparam logic [1:0] BOP_SKIP_SET = 2'h3;

  localparam logic [7:0] MISC_RETURN = 8'h08;
  localparam logic [7:0] MISC_RETIRQ = 8'h09;
  localparam logic [7:0] MISC_SLEEP = 8'h63;
  localparam logic [7:0] MISC_WDOG_CLR = 8'h64;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed
  {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mide_apb_req_s;

  typedef struct packed
  {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mide_apb_rsp_s;

  typedef struct packed
  {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic we;
  } mide_file_req_s;

  typedef struct packed
  {
    logic c;
    logic dc;
    logic [7:0] res;
  } mide_alu_s;

  // Eight-bit add with carry in, giving carry and nibble carry
  function automatic mide_alu_s mide_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return '{c: hi[4], dc: lo[4], res: {hi[3:0], lo[3:0]}};
  endfunction

endpackage

// *** hdl/mide_core.sv ***
// Instruction decode and execute core with an APB control port
//
// Summary of operation
// - Destination bit 0 writes accumulator, 1 writes file
// - Ordinary instructions take one instruction cycle
// - Skips and branches add a second no-operation cycle
// - Instruction cycle is four clock periods
// - Port operand comes from pin levels
// - Timer-zero write clears prescaler when assigned there
// - Don't-care opcode bits are ignored
// - Add literal updates carry, digit carry, zero
// - AND literal updates only zero flag
// - Bit clear touches no status flag
// - Skip when tested bit is clear
// - Skip when tested bit is set
// - Decrement/increment skip on zero, no flags
// - Rotates go through carry, update only carry
// - Standby in one cycle, updates timeout/powerdown flags
// - Literal minus accumulator updates carry, digit carry, zero
// - Return with literal loads accumulator, two cycles
// - XOR literal updates zero flag
// - OR register writes destination, updates zero
// - XOR register writes destination, updates zero
// - Call pushes next address onto stack
// - Call target: immediate low, high latch high
// - Watchdog clear resets counter, sets both flags
`timescale 1ns/1ns

module mide_core
  import mide_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // APB slave
  input wire mide_apb_req_s i_apb,
  output mide_apb_rsp_s o_apb,
  // Program memory
  output logic [12:0] o_prog_addr,
  input wire logic [13:0] i_instr,
  // File register bus
  output mide_file_req_s o_file,
  input wire logic [7:0] i_file_rdata,
  // I/O port pins
  input wire logic [7:0] i_port_pins,
  // Timer, watchdog and power control
  output logic o_prescaler_clr,
  output logic o_watchdog_clr,
  output logic o_sleep
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed
  {
    mide_q_e q;
    logic [12:0] pc;
    logic [7:0][12:0] stack;
    logic [2:0] sp;
    logic [13:0] ir;
    logic ir_valid;
    logic flush;
    logic [7:0] operand;
    logic [7:0] acc;
    logic carry_flag;
    logic digit_carry_flag;
    logic zero_flag;
    logic timeout_flag;
    logic powerdown_flag;
    logic global_irq_allow;
    logic [4:0] pc_high_latch;
    logic run;
    logic psa_timer_zero;
    logic sleep;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    mide_file_req_s file;
    mide_apb_rsp_s rsp;
    logic prescaler_clr;
    logic wdog_clr;
  } mide_state_s;

  mide_state_s st_ff;
  mide_state_s nxt_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [7:0] f_val;
    logic [7:0] w_val;
    logic [7:0] lit;
    logic [7:0] res;
    logic [7:0] mask;
    logic [2:0] bsel;
    logic dsel;
    logic wr_w;
    logic wr_f;
    logic upd_z;
    logic upd_c;
    logic upd_dc;
    logic new_c;
    logic skip;
    logic jump;
    logic push;
    logic pop;
    logic [12:0] target;
    logic [12:0] stack_top;
    logic apb_setup;
    logic apb_write;
    logic mapped;
    logic [31:0] rdata;
    mide_alu_s alu;

    nxt_st = st_ff;
    f_val = st_ff.operand;
    w_val = st_ff.acc;
    lit = st_ff.ir[7:0];
    dsel = st_ff.ir[7];
    bsel = st_ff.ir[9:7];
    mask = 8'h01 << bsel;
    res = 8'h00;
    wr_w = 1'b0;
    wr_f = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    new_c = st_ff.carry_flag;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    target = {st_ff.pc_high_latch[4:3], st_ff.ir[10:0]};
    stack_top = st_ff.stack[st_ff.sp - 3'h1];
    alu = mide_add(w_val, f_val, 1'b0);
    rdata = 32'h0000_0000;
    mapped = 1'b1;

    // Pulses last one clock
    nxt_st.prescaler_clr = 1'b0;
    nxt_st.wdog_clr = 1'b0;
    nxt_st.rsp.pready = 1'b0;

    // Pin synchroniser
    nxt_st.pin_meta = i_port_pins;
    nxt_st.pin_sync = st_ff.pin_meta;

    // ----------------------------------------
    // APB slave: one wait-free access cycle
    // ----------------------------------------
    apb_setup = i_apb.psel && !i_apb.penable;
    apb_write = i_apb.psel && i_apb.penable && st_ff.rsp.pready && i_apb.pwrite && !st_ff.rsp.pslverr;
    unique case (i_apb.paddr)
      REG_CTRL:
        rdata = {29'h0, 1'b0, st_ff.psa_timer_zero, st_ff.run};
      REG_STATUS:
      begin
        rdata[ST_C_BIT] = st_ff.carry_flag;
        rdata[ST_DC_BIT] = st_ff.digit_carry_flag;
        rdata[ST_Z_BIT] = st_ff.zero_flag;
        rdata[ST_PWRDN_BIT] = st_ff.powerdown_flag;
        rdata[ST_TMOUT_BIT] = st_ff.timeout_flag;
        rdata[ST_IRQ_EN_BIT] = st_ff.global_irq_allow;
        rdata[ST_SLEEP_BIT] = st_ff.sleep;
      end
      REG_ACC:
        rdata = {24'h0, st_ff.acc};
      REG_PC:
        rdata = {19'h0, st_ff.pc};
      REG_PC_HIGH:
        rdata = {27'h0, st_ff.pc_high_latch};
      default:
        mapped = 1'b0;
    endcase
    if (apb_setup)
    begin
      nxt_st.rsp.pready = 1'b1;
      nxt_st.rsp.pslverr = !mapped;
      nxt_st.rsp.prdata = (mapped && !i_apb.pwrite) ? rdata : 32'h0000_0000;
    end
    if (apb_write)
    begin
      if (i_apb.paddr == REG_CTRL)
      begin
        nxt_st.run = i_apb.pwdata[CTRL_RUN_BIT];
        nxt_st.psa_timer_zero = i_apb.pwdata[CTRL_PSA_BIT];
        if (i_apb.pwdata[CTRL_WAKE_BIT])
        begin
          nxt_st.sleep = 1'b0;
        end
      end
      if (i_apb.paddr == REG_PC_HIGH)
      begin
        nxt_st.pc_high_latch = i_apb.pwdata[4:0];
      end
    end

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    unique case (st_ff.ir[13:12])
      GRP_BYTE:
      begin
        wr_w = !dsel;
        wr_f = dsel;
        unique case (st_ff.ir[11:8])
          OP_MISC:
          begin
            res = w_val;
            wr_w = 1'b0;
            if (!dsel)
            begin
              wr_f = 1'b0;
              // Unlisted low patterns other than sleep and watchdog clear behave as no operation
              unique case (st_ff.ir[7:0])
                MISC_RETURN:
                begin
                  pop = 1'b1;
                  jump = 1'b1;
                  target = stack_top;
                end
                MISC_RETIRQ:
                begin
                  pop = 1'b1;
                  jump = 1'b1;
                  target = stack_top;
                end
                default:
                  res = w_val;
              endcase
            end
          end
          OP_CLR:
          begin
            res = 8'h00;
            upd_z = 1'b1;
          end
          OP_SUB:
          begin
            alu = mide_add(f_val, ~w_val, 1'b1);
            res = alu.res;
            upd_z = 1'b1;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          OP_DEC:
          begin
            res = f_val - 8'h01;
            upd_z = 1'b1;
          end
          OP_IOR:
          begin
            res = w_val | f_val;
            upd_z = 1'b1;
          end
          OP_AND:
          begin
            res = w_val & f_val;
            upd_z = 1'b1;
          end
          OP_XOR:
          begin
            res = w_val ^ f_val;
            upd_z = 1'b1;
          end
          OP_ADD:
          begin
            res = alu.res;
            upd_z = 1'b1;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          OP_MOV:
          begin
            res = f_val;
            upd_z = 1'b1;
          end
          OP_COM:
          begin
            res = ~f_val;
            upd_z = 1'b1;
          end
          OP_INC:
          begin
            res = f_val + 8'h01;
            upd_z = 1'b1;
          end
          OP_DECSZ:
          begin
            res = f_val - 8'h01;
            skip = (res == 8'h00);
          end
          OP_RR:
          begin
            res = {st_ff.carry_flag, f_val[7:1]};
            new_c = f_val[0];
            upd_c = 1'b1;
          end
          OP_RL:
          begin
            res = {f_val[6:0], st_ff.carry_flag};
            new_c = f_val[7];
            upd_c = 1'b1;
          end
          OP_SWAP:
            res = {f_val[3:0], f_val[7:4]};
          OP_INCSZ:
          begin
            res = f_val + 8'h01;
            skip = (res == 8'h00);
          end
        endcase
      end
      GRP_BIT:
      begin
        unique case (st_ff.ir[11:10])
          BOP_CLEAR:
          begin
            res = f_val & ~mask;
            wr_f = 1'b1;
          end
          BOP_SET:
          begin
            res = f_val | mask;
            wr_f = 1'b1;
          end
          BOP_SKIP_CLR:
            skip = !f_val[bsel];
          BOP_SKIP_SET:
            skip = f_val[bsel];
        endcase
      end
      GRP_BRANCH:
      begin
        jump = 1'b1;
        push = !st_ff.ir[11];
      end
      GRP_LIT:
      begin
        wr_w = 1'b1;
        // Don't-care opcode bits fall into wildcard arms
        casez (st_ff.ir[11:8])
          4'b00??:
            res = lit;
          4'b01??:
          begin
            res = lit;
            pop = 1'b1;
            jump = 1'b1;
            target = stack_top;
          end
          4'b1000:
          begin
            res = w_val | lit;
            upd_z = 1'b1;
          end
          4'b1001:
          begin
            res = w_val & lit;
            upd_z = 1'b1;
          end
          4'b1010:
          begin
            res = w_val ^ lit;
            upd_z = 1'b1;
          end
          4'b110?:
          begin
            alu = mide_add(lit, ~w_val, 1'b1);
            res = alu.res;
            upd_z = 1'b1;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          4'b111?:
          begin
            alu = mide_add(w_val, lit, 1'b0);
            res = alu.res;
            upd_z = 1'b1;
            upd_c = 1'b1;
            upd_dc = 1'b1;
          end
          default:
            wr_w = 1'b0;
        endcase
      end
    endcase
    if (upd_c && !(st_ff.ir[13:12] == GRP_BYTE && (st_ff.ir[11:8] == OP_RR || st_ff.ir[11:8] == OP_RL)))
    begin
      new_c = alu.c;
    end

    // ----------------------------------------
    // Four-phase instruction cycle
    // ----------------------------------------
    unique case (st_ff.q)
      MIDE_Q1:
      begin
        if (st_ff.run && !st_ff.sleep)
        begin
          nxt_st.q = MIDE_Q2;
          // Flushed cycle fetches nothing and runs as no operation
          nxt_st.ir_valid = !st_ff.flush;
          nxt_st.flush = 1'b0;
          if (!st_ff.flush)
          begin
            nxt_st.ir = i_instr;
            nxt_st.pc = st_ff.pc + 13'h0001;
            nxt_st.file.addr = i_instr[6:0];
          end
        end
      end
      MIDE_Q2:
      begin
        nxt_st.q = MIDE_Q3;
        nxt_st.operand = (st_ff.file.addr == ADDR_IO_PORT) ? st_ff.pin_sync : i_file_rdata;
      end
      MIDE_Q3:
      begin
        nxt_st.q = MIDE_Q4;
        if (st_ff.ir_valid)
        begin
          if (wr_w)
          begin
            nxt_st.acc = res;
          end
          if (wr_f)
          begin
            nxt_st.file.we = 1'b1;
            nxt_st.file.wdata = res;
            nxt_st.prescaler_clr = (st_ff.file.addr == ADDR_TIMER_ZERO) && st_ff.psa_timer_zero;
          end
          if (upd_z)
          begin
            nxt_st.zero_flag = (res == 8'h00);
          end
          if (upd_c)
          begin
            nxt_st.carry_flag = new_c;
          end
          if (upd_dc)
          begin
            nxt_st.digit_carry_flag = alu.dc;
          end
          if (push)
          begin
            nxt_st.stack[st_ff.sp] = st_ff.pc;
            nxt_st.sp = st_ff.sp + 3'h1;
          end
          if (pop)
          begin
            nxt_st.sp = st_ff.sp - 3'h1;
          end
          if (st_ff.ir[13:0] == {GRP_BYTE, OP_MISC, MISC_RETIRQ})
          begin
            nxt_st.global_irq_allow = 1'b1;
          end
          if (st_ff.ir[13:0] == {GRP_BYTE, OP_MISC, MISC_SLEEP})
          begin
            nxt_st.sleep = 1'b1;
            nxt_st.wdog_clr = 1'b1;
            nxt_st.powerdown_flag = 1'b0;
            nxt_st.timeout_flag = 1'b1;
          end
          if (st_ff.ir[13:0] == {GRP_BYTE, OP_MISC, MISC_WDOG_CLR})
          begin
            nxt_st.wdog_clr = 1'b1;
            nxt_st.powerdown_flag = 1'b1;
            nxt_st.timeout_flag = 1'b1;
          end
          // Only a taken skip, a branch or a return costs the extra cycle
          if (jump)
          begin
            nxt_st.pc = target;
            nxt_st.flush = 1'b1;
          end
          else if (skip)
          begin
            nxt_st.pc = st_ff.pc + 13'h0001;
            nxt_st.flush = 1'b1;
          end
        end
      end
      MIDE_Q4:
      begin
        nxt_st.q = MIDE_Q1;
        nxt_st.file.we = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st_ff <= '0;
      st_ff.q <= MIDE_Q1;
      st_ff.pc <= RST_PC;
      st_ff.acc <= RST_ACC;
      st_ff.pc_high_latch <= RST_PC_HIGH;
      st_ff.timeout_flag <= RST_TIMEOUT;
      st_ff.powerdown_flag <= RST_POWERDOWN;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_apb = st_ff.rsp;
  assign o_prog_addr = st_ff.pc;
  assign o_file = st_ff.file;
  assign o_prescaler_clr = st_ff.prescaler_clr;
  assign o_watchdog_clr = st_ff.wdog_clr;
  assign o_sleep = st_ff.sleep;

endmodule

// *** sim/mide_core_chk.sv ***
// Port checker for the decode/execute core
`timescale 1ns/1ns
module mide_core_chk
  import mide_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Watched ports
  input wire mide_apb_req_s i_apb,
  input wire mide_apb_rsp_s o_apb,
  input wire logic [12:0] o_prog_addr,
  input wire logic [13:0] i_instr,
  input wire mide_file_req_s o_file,
  input wire logic [7:0] i_file_rdata,
  input wire logic [7:0] i_port_pins,
  input wire logic o_prescaler_clr,
  input wire logic o_watchdog_clr,
  input wire logic o_sleep
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  reset_clears_a: assert property ($fell(i_srst) |-> o_prog_addr == RST_PC && !o_apb.pready && !o_file.we && !o_sleep)
    else $error("outputs not cleared by reset");
  write_spacing_a: assert property (o_file.we |=> !o_file.we [*3])
    else $error("file writes closer than one instruction cycle");
  apb_ready_a: assert property (i_apb.psel && !i_apb.penable |=> o_apb.pready)
    else $error("no ready in first access cycle");
  ready_pulse_a: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("ready held longer than one cycle");
  unmapped_err_a: assert property (i_apb.psel && i_apb.penable && o_apb.pready && i_apb.paddr > REG_PC_HIGH
    |-> o_apb.pslverr && o_apb.prdata == 32'h0)
    else $error("unmapped access not refused");
  prescaler_clr_a: assert property (o_prescaler_clr |-> o_file.we && o_file.addr == ADDR_TIMER_ZERO)
    else $error("prescaler clear without timer write");
  wdog_pulse_a: assert property (o_watchdog_clr |=> !o_watchdog_clr [*3])
    else $error("watchdog clear longer than one pulse");
  sleep_hold_a: assert property (o_sleep && $past(o_sleep) |-> $stable(o_prog_addr) && !o_file.we)
    else $error("core active in standby");
endmodule

bind mide_core mide_core_chk u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_apb(i_apb), .o_apb(o_apb),
  .o_prog_addr(o_prog_addr), .i_instr(i_instr), .o_file(o_file), .i_file_rdata(i_file_rdata),
  .i_port_pins(i_port_pins), .o_prescaler_clr(o_prescaler_clr), .o_watchdog_clr(o_watchdog_clr),
  .o_sleep(o_sleep));

// *** sim/mide_mem_model.sv ***
// Program memory and file register model facing the core
`timescale 1ns/1ns
module mide_mem_model
  import mide_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Core side
  input wire logic [12:0] i_prog_addr,
  output logic [13:0] o_instr,
  input wire mide_file_req_s i_file,
  output logic [7:0] o_file_rdata
);
  logic [13:0] rom_mem [0:8191];
  logic [7:0] ram_mem [0:127];

  assign o_instr = rom_mem[i_prog_addr];
  assign o_file_rdata = ram_mem[i_file.addr];

  always @(posedge i_clk)
  begin
    if (i_file.we === 1'b1)
    begin
      ram_mem[i_file.addr] <= i_file.wdata;
    end
  end
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the decode/execute core
`timescale 1ns/1ns
module testbench
  import mide_pkg::*;
;
  logic clk;
  logic srst;
  mide_apb_req_s apb;
  mide_apb_rsp_s apb_rsp;
  logic [12:0] prog_addr;
  logic [13:0] instr;
  mide_file_req_s file_req;
  logic [7:0] file_rdata;
  logic [7:0] port_pins;
  logic pclr;
  logic wdog_clr;
  logic sleep;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int t_wr = 0;
  int t_wdog = 0;
  int n_pclr = 0;
  int n_wdog = 0;
  logic [31:0] rd;
  logic [13:0] prog [0:18] = '{14'h3e15, 14'h390f, 14'h3a05, 14'h3c03, 14'h04a0, 14'h0620, 14'h1220,
    14'h1a20, 14'h3e01, 14'h1c20, 14'h3e01, 14'h0ba1, 14'h3e01, 14'h0d20, 14'h0081, 14'h0406,
    14'h00a2, 14'h2020, 14'h0063};

  mide_core dut (.i_clk(clk), .i_srst(srst), .i_apb(apb), .o_apb(apb_rsp), .o_prog_addr(prog_addr),
    .i_instr(instr), .o_file(file_req), .i_file_rdata(file_rdata), .i_port_pins(port_pins),
    .o_prescaler_clr(pclr), .o_watchdog_clr(wdog_clr), .o_sleep(sleep));
  mide_mem_model u_mem (.i_clk(clk), .i_prog_addr(prog_addr), .o_instr(instr), .i_file(file_req),
    .o_file_rdata(file_rdata));

  initial
  begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  // Pulse timing monitor
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (file_req.we === 1'b1 && t_wr == 0)
      t_wr <= cyc;
    if (wdog_clr === 1'b1)
    begin
      t_wdog <= cyc;
      n_wdog <= n_wdog + 1;
    end
    if (pclr === 1'b1)
      n_pclr <= n_pclr + 1;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge clk);
    apb.penable <= 1'b1;
    @(posedge clk);
    while (apb_rsp.pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 20)
    begin
      failures++;
      test_done();
    end
    rd = apb_rsp.prdata;
    chk("pslverr", {31'h0, apb_rsp.pslverr}, {31'h0, addr > REG_PC_HIGH});
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int n;
    srst = 1'b1;
    apb = '0;
    port_pins = 8'h81;
    for (int i = 0; i < 8192; i++)
      u_mem.rom_mem[i] = 14'h0000;
    for (int i = 0; i < 128; i++)
      u_mem.ram_mem[i] = 8'h00;
    for (int i = 0; i < 19; i++)
      u_mem.rom_mem[i] = prog[i];
    u_mem.rom_mem[32] = 14'h0064;
    u_mem.rom_mem[33] = 14'h2828;
    u_mem.rom_mem[40] = 14'h3799;
    u_mem.ram_mem[32] = 8'h30;
    u_mem.ram_mem[33] = 8'h01;
    u_mem.ram_mem[6] = 8'h5a;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb_xfer(1'b0, REG_STATUS, 32'h0);
    chk("status_rst", rd, 32'h18);
    apb_xfer(1'b1, REG_PC_HIGH, 32'hff);
    apb_xfer(1'b0, REG_PC_HIGH, 32'h0);
    chk("pc_high", rd, 32'h1f);
    // Low latch bits set, so a target using them would miss
    apb_xfer(1'b1, REG_PC_HIGH, 32'h07);
    apb_xfer(1'b1, REG_ACC, 32'h55);
    apb_xfer(1'b0, REG_ACC, 32'h0);
    chk("acc_ro", rd, 32'h0);
    apb_xfer(1'b0, 12'h014, 32'h0);
    chk("unmapped", rd, 32'h0);
    apb_xfer(1'b1, REG_CTRL, 32'h3);
    n = 0;
    while (sleep !== 1'b1 && n < 400)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 400)
    begin
      failures++;
      test_done();
    end
    repeat (4) @(posedge clk);
    apb_xfer(1'b0, REG_ACC, 32'h0);
    chk("acc", rd, 32'h99);
    apb_xfer(1'b0, REG_STATUS, 32'h0);
    chk("status", rd, 32'h52);
    apb_xfer(1'b0, REG_PC, 32'h0);
    chk("pc", rd, 32'h13);
    chk("f20", {24'h0, u_mem.ram_mem[32]}, 32'h23);
    chk("f21", {24'h0, u_mem.ram_mem[33]}, 32'h00);
    chk("timer", {24'h0, u_mem.ram_mem[1]}, 32'h47);
    chk("f22", {24'h0, u_mem.ram_mem[34]}, 32'hc7);
    chk("cycles", 32'(t_wdog - t_wr), 32'(20 * OSC_PER_INSTR));
    chk("pclr", 32'(n_pclr), 32'd1);
    chk("wdog_pulses", 32'(n_wdog), 32'd2);
    apb_xfer(1'b1, REG_CTRL, 32'h4);
    @(posedge clk);
    chk("sleep", {31'h0, sleep}, 32'h0);
    apb_xfer(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    test_done();
  end
endmodule
